// File: low_power_state_control.v
`timescale 1ns/1ps
`default_nettype none
`include "sleep_ctl_map.vh"
module low_power_state_control (
   input  wire        core_clk,
   input  wire        rst_n,
   input  wire [3:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_write,
   input  wire        reg_read,
   output reg  [31:0] reg_rdata,
   output reg         mem_write,
   output reg  [63:0] mem_addr,
   output reg  [63:0] mem_wdata,
   input  wire        mem_ready,
   output reg         halt_fetch,
   output reg         keep_coherent,
   output reg         sleep_ack,
   input  wire        platform_mgmt_interrupt,
   input  wire        machine_check,
   input  wire        restart_event,
   input  wire        reset_wake,
   input  wire        ext_interrupt,
   input  wire        nmi,
   input  wire [3:0]  ext_int_class,
   output reg         core_reset_req,
   output reg  [2:0]  resume_target,
   output reg         resume_pulse
);
   localparam [3:0] ST_IDLE  = 4'b0001;
   localparam [3:0] ST_QUERY = 4'b0010;
   localparam [3:0] ST_SLEEP = 4'b0100;
   localparam [3:0] ST_WAKE  = 4'b1000;

   reg [3:0]  state;
   reg [7:0]  status;
   reg [63:0] buf_addr;
   reg [6:0]  wake_masks;
   reg [2:0]  desc_sel;
   reg [3:0]  slot;
   reg        busy;
   reg [2:0]  next_target;
   reg [2:0]  wake_sync [0:5];
   reg [5:0]  wake_lvl;
   wire [5:0] wake_raw;
   wire [63:0] sel_desc;
   wire        ext_ok;
   integer     i;

   // Packs one descriptor: sync, present, power, sleep delay, wake delay.
   function [63:0] pack_desc;
      input        sync;
      input        present;
      input [27:0] power_mw;
      input [15:0] sleep_cyc;
      input [15:0] wake_cyc;
      begin
         pack_desc = 64'h0;
         pack_desc[`DESC_WAKE_LSB +: 16]  = wake_cyc;
         pack_desc[`DESC_SLEEP_LSB +: 16] = sleep_cyc;
         pack_desc[`DESC_POWER_LSB +: 28] = power_mw;
         pack_desc[`DESC_PRESENT_BIT]     = present;
         pack_desc[`DESC_SYNC_BIT]        = sync;
      end
   endfunction

   // Fixed table; absent slots are all zero so no stale fields leak.
   function [63:0] desc_rom;
      input [2:0] idx;
      begin
         case (idx)
            3'h0:    desc_rom = pack_desc(1'b1, 1'b1, 28'h0000064, 16'h0010, 16'h0010);
            3'h1:    desc_rom = pack_desc(1'b0, 1'b1, 28'h0000032, 16'h0100, 16'h0100);
            default: desc_rom = 64'h0;
         endcase
      end
   endfunction

   assign sel_desc = desc_rom(desc_sel);
   // The non-maskable line has its own channel; the mask logic reads only synchronised wake levels and the raw ext_int_class pins.
   assign wake_raw = {nmi, reset_wake, restart_event, machine_check,
                      platform_mgmt_interrupt, ext_interrupt | nmi};

   // Three-stage synchronisers; a level counts once stages two and three agree.
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < 6; i = i + 1)
            wake_sync[i] <= 3'h0;
         wake_lvl <= 6'h00;
      end else begin
         for (i = 0; i < 6; i = i + 1) begin
            wake_sync[i] <= {wake_sync[i][1:0], wake_raw[i]};
            if (wake_sync[i][1] == wake_sync[i][2])
               wake_lvl[i] <= wake_sync[i][2];
         end
      end
   end

   // Class mask passes classes above it; the all-mask bit blocks every external interrupt but NMI.
   assign ext_ok = (wake_lvl[5] | (!wake_masks[`MASK_ALL_BIT] &&
                   (ext_int_class > wake_masks[`MASK_CLASS_MSB:`MASK_CLASS_LSB])))
                   && wake_lvl[0];

   always @* begin
      next_target = `RESUME_NONE;
      if (wake_lvl[4])
         next_target = `RESUME_RESET;
      else if (wake_lvl[2])
         next_target = wake_masks[`MASK_MC_BIT] ? `RESUME_CALLER : `RESUME_MC;
      else if (wake_lvl[3])
         next_target = wake_masks[`MASK_MC_BIT] ? `RESUME_CALLER : `RESUME_RESTART;
      else if (wake_lvl[1])
         next_target = wake_masks[`MASK_PMI_BIT] ? `RESUME_CALLER : `RESUME_PMI;
      else if (ext_ok)
         next_target = `RESUME_CALLER;
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state          <= ST_IDLE;
         status         <= `STATUS_RESET;
         buf_addr       <= 64'h0;
         wake_masks     <= 7'h00;
         desc_sel       <= 3'h0;
         slot           <= 4'h0;
         busy           <= 1'b0;
         reg_rdata      <= 32'h0;
         mem_write      <= 1'b0;
         mem_addr       <= 64'h0;
         mem_wdata      <= 64'h0;
         halt_fetch     <= 1'b0;
         keep_coherent  <= 1'b0;
         sleep_ack      <= 1'b0;
         core_reset_req <= 1'b0;
         resume_target  <= `RESUME_NONE;
         resume_pulse   <= 1'b0;
      end else begin
         resume_pulse   <= 1'b0;
         core_reset_req <= 1'b0;
         reg_rdata      <= 32'h0;
         if (reg_read) begin
            case (reg_addr)
               `REG_STATUS:      reg_rdata <= {23'h0, busy, status};
               `REG_BUF_ADDR_LO: reg_rdata <= buf_addr[31:0];
               `REG_BUF_ADDR_HI: reg_rdata <= buf_addr[63:32];
               `REG_WAKE_MASKS:  reg_rdata <= {25'h0, wake_masks};
               `REG_RESUME:      reg_rdata <= {29'h0, resume_target};
               `REG_DESC_SEL:    reg_rdata <= {29'h0, desc_sel};
               `REG_DESC_LO:     reg_rdata <= sel_desc[31:0];
               `REG_DESC_HI:     reg_rdata <= sel_desc[63:32];
               default:          reg_rdata <= 32'h0;
            endcase
         end
         if (reg_write) begin
            case (reg_addr)
               `REG_BUF_ADDR_LO: buf_addr[31:0]  <= reg_wdata;
               `REG_BUF_ADDR_HI: buf_addr[63:32] <= reg_wdata;
               `REG_WAKE_MASKS:  wake_masks      <= reg_wdata[6:0];
               `REG_DESC_SEL:    desc_sel        <= reg_wdata[2:0];
               default:          ;
            endcase
         end
         case (state)
            ST_IDLE: begin
               if (reg_write && reg_addr == `REG_COMMAND) begin
                  if (reg_wdata[`CMD_QUERY_BIT] && reg_wdata[`CMD_SLEEP_BIT]) begin
                     status <= `STATUS_BAD_ARG;
                  end else if (reg_wdata[`CMD_QUERY_BIT]) begin
                     if ((buf_addr[31:0] & `BUF_ALIGN_MASK) != 32'h0) begin
                        status <= `STATUS_BAD_ARG;
                     end else begin
                        busy      <= 1'b1;
                        slot      <= 4'h0;
                        mem_write <= 1'b1;
                        mem_addr  <= buf_addr;
                        mem_wdata <= desc_rom(3'h0);
                        state     <= ST_QUERY;
                     end
                  end else if (reg_wdata[`CMD_SLEEP_BIT]) begin
                     busy          <= 1'b1;
                     halt_fetch    <= 1'b1;
                     keep_coherent <= 1'b1;
                     resume_target <= `RESUME_NONE;
                     state         <= ST_SLEEP;
                  end
               end
            end
            ST_QUERY: begin
               if (mem_ready) begin
                  if (slot == `DESC_COUNT - 4'h1) begin
                     mem_write <= 1'b0;
                     busy      <= 1'b0;
                     status    <= `STATUS_OK;
                     state     <= ST_IDLE;
                  end else begin
                     slot      <= slot + 4'h1;
                     mem_addr  <= mem_addr + 64'h8;
                     mem_wdata <= desc_rom(slot[2:0] + 3'h1);
                  end
               end
            end
            ST_SLEEP: begin
               // The acknowledge stands at least one cycle even when a wake is already pending.
               sleep_ack <= 1'b1;
               if (sleep_ack && next_target != `RESUME_NONE) begin
                  sleep_ack     <= 1'b0;
                  halt_fetch    <= 1'b0;
                  keep_coherent <= 1'b0;
                  resume_target <= next_target;
                  state         <= ST_WAKE;
               end
            end
            ST_WAKE: begin
               resume_pulse   <= 1'b1;
               core_reset_req <= (resume_target == `RESUME_RESET);
               busy           <= 1'b0;
               status         <= `STATUS_OK;
               state          <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule // low_power_state_control
`default_nettype wire

// File: sleep_ctl_map.vh
`ifndef SLEEP_CTL_MAP_VH
`define SLEEP_CTL_MAP_VH
// Register indices on the plain register port.
`define REG_COMMAND      4'h0
`define REG_STATUS       4'h1
`define REG_BUF_ADDR_LO  4'h2
`define REG_BUF_ADDR_HI  4'h3
`define REG_WAKE_MASKS   4'h4
`define REG_RESUME       4'h5
`define REG_DESC_SEL     4'h6
`define REG_DESC_LO      4'h7
`define REG_DESC_HI      4'h8
// Command register fields.
`define CMD_QUERY_BIT    0
`define CMD_SLEEP_BIT    1
// Status codes as 8-bit two's complement.
`define STATUS_OK        8'h00
`define STATUS_BAD_ARG   8'hFE
`define STATUS_ERROR     8'hFD
`define STATUS_RESET     8'h00
// Wake mask register fields.
`define MASK_CLASS_LSB   0
`define MASK_CLASS_MSB   3
`define MASK_ALL_BIT     4
`define MASK_PMI_BIT     5
`define MASK_MC_BIT      6
// Descriptor field positions in the 64-bit word.
`define DESC_WAKE_LSB    0
`define DESC_SLEEP_LSB   16
`define DESC_POWER_LSB   32
`define DESC_PRESENT_BIT 60
`define DESC_SYNC_BIT    61
// Resume target codes.
`define RESUME_NONE      3'h0
`define RESUME_CALLER    3'h1
`define RESUME_PMI       3'h2
`define RESUME_MC        3'h3
`define RESUME_RESTART   3'h4
`define RESUME_RESET     3'h5
// Buffer geometry.
`define DESC_COUNT       4'h8
`define BUF_ALIGN_MASK   32'h0000_0007
`endif

// File: low_power_state_control_checker.sv
`timescale 1ns/1ps
`default_nettype none
module low_power_state_control_checker (
   input wire        core_clk,
   input wire        rst_n,
   input wire        mem_write,
   input wire        mem_ready,
   input wire [63:0] mem_addr,
   input wire [63:0] mem_wdata,
   input wire        halt_fetch,
   input wire        keep_coherent,
   input wire        sleep_ack,
   input wire        reset_wake,
   input wire        core_reset_req,
   input wire [2:0]  resume_target,
   input wire        resume_pulse
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_write_hold: assert property (mem_write && !mem_ready |=>
      mem_write && $stable(mem_addr) && $stable(mem_wdata)) else $error("word dropped");
   a_addr_step: assert property (mem_write && mem_ready ##1 mem_write |->
      mem_addr == $past(mem_addr) + 64'h8) else $error("address not ascending");
   a_desc_spare: assert property (mem_write |-> mem_wdata[63:62] == 2'h0)
      else $error("spare descriptor bits set");
   a_sleep_sync: assert property (halt_fetch |-> keep_coherent)
      else $error("asleep without coherence");
   a_ack_after: assert property ($rose(halt_fetch) |=> sleep_ack)
      else $error("no entry acknowledge");
   a_resume_after: assert property ($fell(sleep_ack) |=> resume_pulse)
      else $error("no resume after wake");
   a_reset_wake: assert property (sleep_ack && reset_wake |-> ##[1:8] resume_pulse)
      else $error("reset did not wake");
   a_reset_target: assert property (resume_pulse && resume_target == 3'h5 |-> core_reset_req)
      else $error("reset wake without core reset");
   c_accept: cover property (mem_write && mem_ready);
   c_caller: cover property (resume_pulse && resume_target == 3'h1);
   c_reset: cover property (core_reset_req);
endmodule // low_power_state_control_checker
bind low_power_state_control low_power_state_control_checker i_chk (.*);
`default_nettype wire

// File: platform_model.sv
`timescale 1ns/1ps
`default_nettype none
module platform_model (
   input wire         core_clk,
   input wire         rst_n,
   input wire         mem_write,
   input wire  [63:0] mem_addr,
   input wire  [63:0] mem_wdata,
   input wire         slow,
   input wire         clear_count,
   output logic       mem_ready
);
   logic [63:0] word [0:7];
   logic [63:0] addr [0:7];
   int          n;
   logic [1:0]  cnt;
   // Holds the 64-byte buffer; a slow setting stalls three cycles in four.
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_ready <= 1'b0;
         cnt <= 2'h0;
         n <= 0;
      end else begin
         cnt <= cnt + 2'h1;
         mem_ready <= !slow || cnt == 2'h3;
         if (clear_count) begin
            n <= 0;
         end else if (mem_write && mem_ready && n < 8) begin
            word[n] <= mem_wdata;
            addr[n] <= mem_addr;
            n <= n + 1;
         end
      end
   end
endmodule // platform_model
`default_nettype wire

// File: low_power_state_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module low_power_state_control_tb_top;
   logic core_clk, rst_n, reg_write, reg_read, mem_write, mem_ready, slow, clear_count;
   logic halt_fetch, keep_coherent, sleep_ack, core_reset_req, resume_pulse;
   logic [3:0]  reg_addr, ext_int_class;
   logic [31:0] reg_wdata, reg_rdata;
   logic [63:0] mem_addr, mem_wdata;
   logic [5:0]  wake;
   logic [2:0]  resume_target;
   int          fails, num_checks, i, q, k;
   low_power_state_control i_low_power_state_control (.core_clk(core_clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_ready(mem_ready), .halt_fetch(halt_fetch), .keep_coherent(keep_coherent),
      .sleep_ack(sleep_ack), .platform_mgmt_interrupt(wake[2]), .machine_check(wake[4]),
      .restart_event(wake[3]), .reset_wake(wake[5]), .ext_interrupt(wake[1]), .nmi(wake[0]),
      .ext_int_class(ext_int_class), .core_reset_req(core_reset_req),
      .resume_target(resume_target), .resume_pulse(resume_pulse));
   platform_model i_platform_model (.core_clk(core_clk), .rst_n(rst_n), .mem_write(mem_write),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .slow(slow), .clear_count(clear_count),
      .mem_ready(mem_ready));
   task results;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk) {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge core_clk) reg_write <= 1'b0;
   endtask
   task rd(input logic [3:0] a);
      @(posedge core_clk) {reg_read, reg_addr} <= {1'b1, a};
      @(posedge core_clk) reg_read <= 1'b0;
      #1;
   endtask
   task nap(input logic [6:0] m, input logic [5:0] pre, input logic [5:0] c,
            input logic [3:0] cls, input logic [2:0] tgt);
      wr(4'h4, {25'h0, m});
      ext_int_class <= cls;
      wr(4'h0, 32'h2);
      for (i = 0; sleep_ack !== 1'b1 && i < 50; i++) @(posedge core_clk);
      @(posedge core_clk) wake <= pre;
      #1 chk(halt_fetch & keep_coherent, 1);
      repeat (10) @(posedge core_clk);
      #1 chk(sleep_ack, 1);
      @(posedge core_clk) wake <= c;
      for (i = 0; resume_pulse !== 1'b1 && i < 20; i++) @(posedge core_clk) #1;
      chk(resume_pulse, 1);
      chk(halt_fetch | keep_coherent | sleep_ack, 0);
      chk(resume_target, tgt);
      chk(core_reset_req, tgt == 3'h5);
      @(posedge core_clk) wake <= 6'h0;
      rd(4'h1);
      chk(reg_rdata[8:0], 9'h000);
      rd(4'h5);
      chk(reg_rdata, {29'h0, tgt});
   endtask
   initial begin
      core_clk = 0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      #100000 fails++;
      results;
   end
   initial begin
      {rst_n, reg_write, reg_read, slow, clear_count, reg_addr, reg_wdata, ext_int_class, wake} = '0;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      wr(4'h2, 32'h1004);
      wr(4'h3, 32'h1);
      wr(4'h0, 32'h1);
      repeat (3) @(posedge core_clk);
      #1 chk(mem_write, 0);
      rd(4'h1);
      chk(reg_rdata[7:0], 8'hFE);
      wr(4'h2, 32'h1000);
      for (q = 0; q < 2; q++) begin
         clear_count <= 1'b1;
         slow <= q[0];
         @(posedge core_clk) clear_count <= 1'b0;
         wr(4'h0, 32'h1);
         k = 0;
         do begin rd(4'h1); k++; end while (reg_rdata[8] !== 1'b0 && k < 100);
         chk(reg_rdata[8:0], 9'h000);
         chk(i_platform_model.n, 8);
         for (k = 0; k < 8; k++) begin
            chk(i_platform_model.addr[k], 64'h1_0000_1000 + 64'h8 * k);
            chk(i_platform_model.word[k][60], k < 2);
         end
         chk(i_platform_model.word[0], 64'h3000_0064_0010_0010);
         chk(i_platform_model.word[1], 64'h1000_0032_0100_0100);
      end
      rd(4'h3);
      chk(reg_rdata, 32'h0000_0001);
      wr(4'h0, 32'h3);
      rd(4'h1);
      chk(reg_rdata[7:0], 8'hFE);
      wr(4'h6, 32'h0);
      rd(4'h7);
      chk(reg_rdata, 32'h0010_0010);
      rd(4'h8);
      chk(reg_rdata, 32'h3000_0064);
      rd(4'h9);
      chk(reg_rdata, 32'h0);
      nap(7'h03, 6'h02, 6'h01, 4'h2, 3'h1);
      nap(7'h03, 6'h00, 6'h02, 4'h5, 3'h1);
      nap(7'h13, 6'h02, 6'h01, 4'h5, 3'h1);
      nap(7'h00, 6'h00, 6'h04, 4'h0, 3'h2);
      nap(7'h20, 6'h00, 6'h04, 4'h0, 3'h1);
      nap(7'h00, 6'h00, 6'h10, 4'h0, 3'h3);
      nap(7'h40, 6'h00, 6'h08, 4'h0, 3'h1);
      nap(7'h00, 6'h00, 6'h08, 4'h0, 3'h4);
      nap(7'h00, 6'h00, 6'h20, 4'h0, 3'h5);
      results;
   end
endmodule // low_power_state_control_tb_top
`default_nettype wire
